// file: rtl/cbb_pkg.sv
// Purpose: constants for the cardbus bridge configuration registers
// Assumes: one socket, 32-bit configuration data path
// Notes:   offsets are configuration byte addresses
//
// Behaviour
// [R1] bridge control is 16 bits at 3Eh, reset value 0340h
// [R2] bridge control bits 15..11 and 4 are read-only zero
// [R3] bit 10 enables posting of burst write data both directions
// [R4] bit 9 marks memory window 1 prefetchable, reset one
// [R5] bit 8 marks memory window 0 prefetchable, reset one
// [R6] bit 7 routes card interrupts to legacy IRQ instead of PCI
// [R7] bit 6 or PCI reset asserts the card reset line
// [R8] bit 5 reports card-side master aborts as target abort and system error
// [R9] bit 3 forwards VGA address accesses toward the card
// [R10] bit 2 blocks upper 768 bytes of each 1K in ISA range
// [R11] bit 1 forwards card system error to PCI SERR, else dropped
// [R12] bit 0 reports card parity errors on card parity error signal
// [R13] board identifiers at 40h, 42h reset zero, writable only while lock bit clear
// [R14] legacy base at 44h is index port, plus one is data port
// [R15] legacy base bit 0 reads one, reset 0000_0001h, word aligned
// [R16] system control at 80h resets to 0044_9060h
// [R17] writes leave read-only and reserved bits unchanged
package cbb_pkg;
   // ----------------------------------------------------------------
   // offsets
   // ----------------------------------------------------------------
   localparam logic [7:0]  CTRL_OFF       = 8'h3e;
   localparam logic [7:0]  CTRL_DW_OFF    = 8'h3c;
   localparam logic [7:0]  VENDOR_OFF     = 8'h40;
   localparam logic [7:0]  BOARD_OFF      = 8'h42;
   localparam logic [7:0]  LEGACY_OFF     = 8'h44;
   localparam logic [7:0]  SYSCTL_OFF     = 8'h80;
   // ----------------------------------------------------------------
   // reset values and write masks, dword aligned except 16-bit bridge control
   // ----------------------------------------------------------------
   localparam logic [15:0] CTRL_RESET     = 16'h0340;
   localparam logic [15:0] CTRL_WMASK     = 16'h07ef;
   localparam logic [31:0] IDS_RESET      = 32'h0000_0000;
   localparam logic [31:0] IDS_WMASK      = 32'hffff_ffff;
   localparam logic [31:0] LEGACY_RESET   = 32'h0000_0001;
   localparam logic [31:0] LEGACY_WMASK   = 32'hffff_fffe;
   localparam logic [31:0] SYSCTL_RESET   = 32'h0044_9060;
   localparam logic [31:0] SYSCTL_WMASK   = 32'hc77f_c07b;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_SHIFT      = 16;
   localparam int CTRL_POST_BIT   = 10;
   localparam int CTRL_PF1_BIT    = 9;
   localparam int CTRL_PF0_BIT    = 8;
   localparam int CTRL_IRQ_BIT    = 7;
   localparam int CTRL_CARD_RESET_BIT   = 6;
   localparam int CTRL_MABT_BIT   = 5;
   localparam int CTRL_VGA_BIT    = 3;
   localparam int CTRL_ISA_BIT    = 2;
   localparam int CTRL_SERR_BIT   = 1;
   localparam int CTRL_PERR_BIT   = 0;
   localparam int SYSCTL_LOCK_BIT = 5;
   localparam logic [15:0] ISA_PAGE       = 16'h0000;
endpackage : cbb_pkg

// file: rtl/cbb_cfg_if.sv
// Purpose: configuration write strobe, lanes and data
// Assumes: single clock domain
// Notes:   shared by all register words
`timescale 1ns/100ps
`default_nettype none
interface cbb_cfg_if;
   logic        wr;
   logic [3:0]  be;
   logic [31:0] wdata;
   modport source (output wr, output be, output wdata);
   modport target (input wr, input be, input wdata);
endinterface : cbb_cfg_if
`default_nettype wire

// file: rtl/cbb_cfg_word.sv
// Purpose: one configuration dword with byte lanes and write mask
// Assumes: write strobe is one cycle per access
// Notes:   masked bits keep their value
`timescale 1ns/100ps
`default_nettype none
module cbb_cfg_word #(
   parameter logic [31:0] RESET_VALUE = 32'h0000_0000,
   parameter logic [31:0] WRITE_MASK  = 32'hffff_ffff
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   cbb_cfg_if.target        cfg,
   input  wire logic        sel,
   input  wire logic        wen,
   output logic [31:0]      value_reg
);
   logic [31:0] lane_mask;
   logic [31:0] bit_mask;

   // ----------------------------------------------------------------
   // byte lane mask
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         assign lane_mask[g*8 +: 8] = {8{cfg.be[g]}};
      end
   endgenerate

   assign bit_mask = lane_mask & WRITE_MASK;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         value_reg <= RESET_VALUE;
      end else if (cfg.wr && sel && wen) begin
         value_reg <= (value_reg & ~bit_mask) | (cfg.wdata & bit_mask); // R17
      end
   end
endmodule : cbb_cfg_word
`default_nettype wire

// file: rtl/cbb_bridge_regs.sv
// Purpose: bridge control, board identity, legacy base and system control
// Assumes: configuration accesses arrive as one-cycle strobes
// Notes:   reads answer one cycle after the strobe
`timescale 1ns/100ps
`default_nettype none
module cbb_bridge_regs (
   input  wire logic        CLK_SYS,
   input  wire logic        RESETN,
   input  wire logic        CFG_WR,
   input  wire logic        CFG_RD,
   input  wire logic [7:0]  CFG_ADDR,
   input  wire logic [3:0]  CFG_BE,
   input  wire logic [31:0] CFG_WDATA,
   output logic [31:0]      CFG_RDATA,
   output logic             CFG_RVALID,
   output logic             WRITE_POST_ENABLE,
   output logic             WINDOW1_PREFETCHABLE,
   output logic             WINDOW0_PREFETCHABLE,
   output logic             FUNC_IRQ_ROUTE_SEL,
   output logic             CARD_RESET_N,
   input  wire logic        VGA_ADDR_HIT,
   output logic             VGA_FORWARD,
   input  wire logic        IO_VALID,
   input  wire logic [31:0] IO_ADDR,
   output logic             IO_FORWARD_BLOCK,
   output logic             LEGACY_INDEX_HIT,
   output logic             LEGACY_DATA_HIT,
   input  wire logic        CB_MASTER_ABORT,
   input  wire logic        SERR_ENABLE,
   output logic             PCI_TARGET_ABORT,
   input  wire logic        CARD_SYSTEM_ERROR,
   output logic             PCI_SERR,
   input  wire logic        CARD_PARITY_DETECT,
   output logic             CARD_PARITY_ERROR,
   output logic [31:0]      SYSTEM_CONTROL
);
   localparam int CS = cbb_pkg::CTRL_SHIFT;

   logic [31:0] ctrl_dw;
   logic [31:0] ids_dw;
   logic [31:0] legacy_dw;
   logic [31:0] sysctl_dw;
   logic [15:0] ctrl;
   logic        ident_write_lock;
   logic [31:0] index_addr;
   logic [31:0] rdata_next;
   logic [31:0] cfg_dw_addr;

   cbb_cfg_if cfg ();

   // ----------------------------------------------------------------
   // configuration write path
   // ----------------------------------------------------------------
   assign cfg.wr    = CFG_WR;
   assign cfg.be    = CFG_BE;
   assign cfg.wdata = CFG_WDATA;
   assign cfg_dw_addr = {24'h00_0000, CFG_ADDR[7:2], 2'b00};

   cbb_cfg_word #(
      .RESET_VALUE ({cbb_pkg::CTRL_RESET, 16'h0000}),              // R1
      .WRITE_MASK  ({cbb_pkg::CTRL_WMASK, 16'h0000})               // R2
   ) u_ctrl (
      .clk       (CLK_SYS),
      .rst_n     (RESETN),
      .cfg       (cfg),
      .sel       (cfg_dw_addr[7:0] == cbb_pkg::CTRL_DW_OFF),
      .wen       (1'b1),
      .value_reg (ctrl_dw)
   );

   cbb_cfg_word #(
      .RESET_VALUE (cbb_pkg::IDS_RESET),
      .WRITE_MASK  (cbb_pkg::IDS_WMASK)
   ) u_ids (
      .clk       (CLK_SYS),
      .rst_n     (RESETN),
      .cfg       (cfg),
      .sel       (cfg_dw_addr[7:0] == cbb_pkg::VENDOR_OFF),
      .wen       (!ident_write_lock),                               // R13
      .value_reg (ids_dw)
   );

   cbb_cfg_word #(
      .RESET_VALUE (cbb_pkg::LEGACY_RESET),                         // R15
      .WRITE_MASK  (cbb_pkg::LEGACY_WMASK)
   ) u_legacy (
      .clk       (CLK_SYS),
      .rst_n     (RESETN),
      .cfg       (cfg),
      .sel       (cfg_dw_addr[7:0] == cbb_pkg::LEGACY_OFF),
      .wen       (1'b1),
      .value_reg (legacy_dw)
   );

   cbb_cfg_word #(
      .RESET_VALUE (cbb_pkg::SYSCTL_RESET),                         // R16
      .WRITE_MASK  (cbb_pkg::SYSCTL_WMASK)
   ) u_sysctl (
      .clk       (CLK_SYS),
      .rst_n     (RESETN),
      .cfg       (cfg),
      .sel       (cfg_dw_addr[7:0] == cbb_pkg::SYSCTL_OFF),
      .wen       (1'b1),
      .value_reg (sysctl_dw)
   );

   assign ctrl             = ctrl_dw[CS +: 16];
   assign ident_write_lock = sysctl_dw[cbb_pkg::SYSCTL_LOCK_BIT];
   assign SYSTEM_CONTROL   = sysctl_dw;

   // ----------------------------------------------------------------
   // configuration read path
   // ----------------------------------------------------------------
   always_comb begin
      rdata_next = 32'h0000_0000;
      unique case (cfg_dw_addr[7:0])
         cbb_pkg::CTRL_DW_OFF: rdata_next = ctrl_dw;
         cbb_pkg::VENDOR_OFF:  rdata_next = ids_dw;
         cbb_pkg::LEGACY_OFF:  rdata_next = legacy_dw;
         cbb_pkg::SYSCTL_OFF:  rdata_next = sysctl_dw;
         default:              rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         CFG_RDATA  <= 32'h0000_0000;
         CFG_RVALID <= 1'b0;
      end else begin
         CFG_RVALID <= CFG_RD;
         if (CFG_RD) begin
            CFG_RDATA <= rdata_next;
         end
      end
   end

   // ----------------------------------------------------------------
   // static controls
   // ----------------------------------------------------------------
   assign WRITE_POST_ENABLE    = ctrl[cbb_pkg::CTRL_POST_BIT];     // R3
   assign WINDOW1_PREFETCHABLE = ctrl[cbb_pkg::CTRL_PF1_BIT];      // R4
   assign WINDOW0_PREFETCHABLE = ctrl[cbb_pkg::CTRL_PF0_BIT];      // R5
   assign FUNC_IRQ_ROUTE_SEL   = ctrl[cbb_pkg::CTRL_IRQ_BIT];      // R6
   assign CARD_RESET_N = RESETN & ~ctrl[cbb_pkg::CTRL_CARD_RESET_BIT];   // R7

   // ----------------------------------------------------------------
   // address forwarding decode
   // ----------------------------------------------------------------
   assign index_addr = {legacy_dw[31:1], 1'b0};

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         VGA_FORWARD      <= 1'b0;
         IO_FORWARD_BLOCK <= 1'b0;
         LEGACY_INDEX_HIT <= 1'b0;
         LEGACY_DATA_HIT  <= 1'b0;
      end else begin
         VGA_FORWARD      <= VGA_ADDR_HIT & ctrl[cbb_pkg::CTRL_VGA_BIT];       // R9
         IO_FORWARD_BLOCK <= IO_VALID & ctrl[cbb_pkg::CTRL_ISA_BIT]
                             & (IO_ADDR[31:16] == cbb_pkg::ISA_PAGE)
                             & (IO_ADDR[9:8] != 2'b00);                       // R10
         LEGACY_INDEX_HIT <= IO_VALID & (IO_ADDR == index_addr);              // R14
         LEGACY_DATA_HIT  <= IO_VALID & (IO_ADDR == index_addr + 32'h1);      // R14
      end
   end

   // ----------------------------------------------------------------
   // error reporting
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         PCI_TARGET_ABORT  <= 1'b0;
         PCI_SERR          <= 1'b0;
         CARD_PARITY_ERROR <= 1'b0;
      end else begin
         PCI_TARGET_ABORT  <= CB_MASTER_ABORT & ctrl[cbb_pkg::CTRL_MABT_BIT]; // R8
         PCI_SERR          <= (CB_MASTER_ABORT & ctrl[cbb_pkg::CTRL_MABT_BIT]
                               & SERR_ENABLE)                                 // R8
                              | (CARD_SYSTEM_ERROR
                                 & ctrl[cbb_pkg::CTRL_SERR_BIT]);             // R11
         CARD_PARITY_ERROR <= CARD_PARITY_DETECT & ctrl[cbb_pkg::CTRL_PERR_BIT]; // R12
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);

   property p_ctrl_reserved;
      (ctrl[15:11] == 5'h00) && (ctrl[4] == 1'b0);
   endproperty
   a_ctrl_reserved: assert property (p_ctrl_reserved) // R2
      else $error("bridge control reserved bit set");

   property p_ctrl_write;
      (CFG_WR && {CFG_ADDR[7:2], 2'b00} == cbb_pkg::CTRL_DW_OFF && CFG_BE[3:2] == 2'b11)
         |=> (ctrl == ($past(CFG_WDATA[31:16]) & cbb_pkg::CTRL_WMASK));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) // R1
      else $error("bridge control write not stored");

   property p_card_reset;
      ctrl[cbb_pkg::CTRL_CARD_RESET_BIT] |-> !CARD_RESET_N;
   endproperty
   a_card_reset: assert property (p_card_reset) // R7
      else $error("card reset not asserted");

   property p_master_abort;
      (CB_MASTER_ABORT && ctrl[cbb_pkg::CTRL_MABT_BIT])
         |=> PCI_TARGET_ABORT && (PCI_SERR || !$past(SERR_ENABLE));
   endproperty
   a_master_abort: assert property (p_master_abort) // R8
      else $error("master abort not reported");

   property p_isa_block;
      (IO_VALID && ctrl[cbb_pkg::CTRL_ISA_BIT] && IO_ADDR[31:16] == 16'h0000
         && IO_ADDR[9:8] == 2'b11) |=> IO_FORWARD_BLOCK;
   endproperty
   a_isa_block: assert property (p_isa_block) // R10
      else $error("isa upper range forwarded");

   property p_serr_drop;
      (!ctrl[cbb_pkg::CTRL_SERR_BIT] && !CB_MASTER_ABORT) |=> !PCI_SERR;
   endproperty
   a_serr_drop: assert property (p_serr_drop) // R11
      else $error("card system error not dropped");

   property p_parity;
      CARD_PARITY_DETECT |=> (CARD_PARITY_ERROR == $past(ctrl[cbb_pkg::CTRL_PERR_BIT]));
   endproperty
   a_parity: assert property (p_parity) // R12
      else $error("card parity report wrong");

   property p_ident_lock;
      (CFG_WR && CFG_ADDR[7:2] == 6'h10 && ident_write_lock) |=> $stable(ids_dw);
   endproperty
   a_ident_lock: assert property (p_ident_lock) // R13
      else $error("board identity written while locked");

   property p_legacy_data;
      (IO_VALID && IO_ADDR == {legacy_dw[31:1], 1'b1}) |=> LEGACY_DATA_HIT;
   endproperty
   a_legacy_data: assert property (p_legacy_data) // R14
      else $error("legacy data port missed");

   property p_legacy_bit0;
      legacy_dw[0] == 1'b1;
   endproperty
   a_legacy_bit0: assert property (p_legacy_bit0) // R15
      else $error("legacy base bit 0 not one");

   property p_sysctl_ro;
      (sysctl_dw & ~cbb_pkg::SYSCTL_WMASK) == (cbb_pkg::SYSCTL_RESET & ~cbb_pkg::SYSCTL_WMASK);
   endproperty
   a_sysctl_ro: assert property (p_sysctl_ro) // R17
      else $error("system control read-only bit changed");

   property p_read_answer;
      CFG_RD |=> CFG_RVALID ##1 !CFG_RVALID || $past(CFG_RD);
   endproperty
   a_read_answer: assert property (p_read_answer) // reads answer one cycle after the strobe
      else $error("read answer timing wrong");

   property p_vga_hit;
      VGA_ADDR_HIT |=> (VGA_FORWARD == $past(ctrl[cbb_pkg::CTRL_VGA_BIT]));
   endproperty
   a_vga_hit: assert property (p_vga_hit) // R9
      else $error("vga access forwarding wrong");

   property p_vga_miss;
      !VGA_ADDR_HIT |=> !VGA_FORWARD;
   endproperty
   a_vga_miss: assert property (p_vga_miss) // R9
      else $error("non-vga access forwarded");

   property p_isa_pass;
      (!IO_VALID || !ctrl[cbb_pkg::CTRL_ISA_BIT] || IO_ADDR[9:8] == 2'b00
         || IO_ADDR[31:16] != cbb_pkg::ISA_PAGE) |=> !IO_FORWARD_BLOCK;
   endproperty
   a_isa_pass: assert property (p_isa_pass) // R10
      else $error("io access blocked outside upper range");

   property p_legacy_index;
      (IO_VALID && IO_ADDR == {legacy_dw[31:1], 1'b0})
         |=> LEGACY_INDEX_HIT && !LEGACY_DATA_HIT;
   endproperty
   a_legacy_index: assert property (p_legacy_index) // R14
      else $error("legacy index port missed");

   property p_serr_forward;
      (CARD_SYSTEM_ERROR && ctrl[cbb_pkg::CTRL_SERR_BIT]) |=> PCI_SERR;
   endproperty
   a_serr_forward: assert property (p_serr_forward) // R11
      else $error("card system error not forwarded");

   property p_abort_quiet;
      (!CB_MASTER_ABORT || !ctrl[cbb_pkg::CTRL_MABT_BIT]) |=> !PCI_TARGET_ABORT;
   endproperty
   a_abort_quiet: assert property (p_abort_quiet) // R8
      else $error("target abort without reported master abort");

   property p_ident_write;
      (CFG_WR && {CFG_ADDR[7:2], 2'b00} == cbb_pkg::VENDOR_OFF && CFG_BE == 4'hf
         && !ident_write_lock) |=> (ids_dw == $past(CFG_WDATA));
   endproperty
   a_ident_write: assert property (p_ident_write) // R13
      else $error("board identity write not stored");

   property p_legacy_write;
      (CFG_WR && {CFG_ADDR[7:2], 2'b00} == cbb_pkg::LEGACY_OFF && CFG_BE == 4'hf)
         |=> (legacy_dw == ($past(CFG_WDATA) | cbb_pkg::LEGACY_RESET));
   endproperty
   a_legacy_write: assert property (p_legacy_write) // R15
      else $error("legacy base write not stored");
endmodule : cbb_bridge_regs
`default_nettype wire

// file: verif/cbb_host_model.sv
// Purpose: configuration host issuing one-cycle read and write strobes
// Assumes: strobes sampled on rising clk
// Notes:   released address, lane and data lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module cbb_host_model (
   input  wire logic        clk,
   output logic             cfg_wr,
   output logic             cfg_rd,
   output logic [7:0]       cfg_addr,
   output logic [3:0]       cfg_be,
   output logic [31:0]      cfg_wdata
);
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 8'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0000_0000;
   end
   // ----------------------------------------------------------------
   // one access, held for exactly one sampling edge
   // ----------------------------------------------------------------
   task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                         input logic [31:0] d);
      @(posedge clk);
      #1;
      cfg_wr = wr;
      cfg_rd = ~wr;
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      @(posedge clk);
      #1;
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = ~cfg_addr;
      cfg_be = ~cfg_be;
      cfg_wdata = ~cfg_wdata;
   endtask : access
endmodule : cbb_host_model
`default_nettype wire

// file: verif/cardbus_bridge_config_regs_test.sv
// Purpose: self-checking bench for the bridge configuration registers
// Assumes: reads answer one cycle after the strobe
// Notes:   expected read data queued by the driver, checked on valid
`timescale 1ns/100ps
`default_nettype none
module cardbus_bridge_config_regs_test;
   logic        clk_sys, resetn, cfg_wr, cfg_rd, rvalid, vga, iov, mabt, serren, card_system_error, cpd;
   logic [7:0]  cfg_addr;
   logic [3:0]  cfg_be;
   logic [31:0] cfg_wdata, rdata, io_addr, sysctl, base_exp, rnd, w;
   logic        wpe, pf1, pf0, irq, card_reset_n, vga_fwd, blk, idx_hit, dat_hit, tabt, serr, perr;
   logic [15:0] ctrl_exp;
   logic [31:0] exp_q[$];
   int          bad_count, n_compared;

   cbb_host_model cbb_host_model_i (.clk(clk_sys), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
   cbb_bridge_regs cbb_bridge_regs_i (.CLK_SYS(clk_sys), .RESETN(resetn), .CFG_WR(cfg_wr),
      .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata),
      .CFG_RDATA(rdata), .CFG_RVALID(rvalid), .WRITE_POST_ENABLE(wpe),
      .WINDOW1_PREFETCHABLE(pf1), .WINDOW0_PREFETCHABLE(pf0), .FUNC_IRQ_ROUTE_SEL(irq),
      .CARD_RESET_N(card_reset_n), .VGA_ADDR_HIT(vga), .VGA_FORWARD(vga_fwd), .IO_VALID(iov),
      .IO_ADDR(io_addr), .IO_FORWARD_BLOCK(blk), .LEGACY_INDEX_HIT(idx_hit),
      .LEGACY_DATA_HIT(dat_hit), .CB_MASTER_ABORT(mabt), .SERR_ENABLE(serren),
      .PCI_TARGET_ABORT(tabt), .CARD_SYSTEM_ERROR(card_system_error), .PCI_SERR(serr),
      .CARD_PARITY_DETECT(cpd), .CARD_PARITY_ERROR(perr), .SYSTEM_CONTROL(sysctl));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out;
      if (bad_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      rnd = xs(rnd);
      cbb_host_model_i.access(1'b0, a, 4'hf, rnd);
   endtask : rd
   task automatic set_ctrl(input logic [15:0] d);
      cbb_host_model_i.access(1'b1, 8'h3e, 4'hc, {d, 16'h0000});
      ctrl_exp = (d & cbb_pkg::CTRL_WMASK) | (cbb_pkg::CTRL_RESET & ~cbb_pkg::CTRL_WMASK);
      check({pf1, pf0, irq, card_reset_n}, {ctrl_exp[9:7], ~ctrl_exp[6]});
      check(wpe, ctrl_exp[10]);
   endtask : set_ctrl
   task automatic side_round(input int n);
      logic [31:0] a, li;
      for (int k = 0; k < n; k++) begin
         rnd = xs(rnd);
         a = xs(rnd ^ 32'h5a5a_0f0f);
         li = {base_exp[31:1], 1'b0};
         if (rnd[9:8] == 2'd0) a[31:16] = 16'h0000;
         if (rnd[9:8] == 2'd1) a = li;
         if (rnd[9:8] == 2'd2) a = li + 32'h1;
         {vga, iov, mabt, serren, card_system_error, cpd} = rnd[5:0];
         io_addr = a;
         @(posedge clk_sys);
         #1;
         check(vga_fwd, rnd[5] & ctrl_exp[3]);
         check(blk, rnd[4] & ctrl_exp[2] & (a[31:16] == 16'h0) & (a[9:8] != 2'd0));
         check({idx_hit, dat_hit}, {rnd[4] & (a == li), rnd[4] & (a == li + 32'h1)});
         check({tabt, perr}, {rnd[3] & ctrl_exp[5], rnd[0] & ctrl_exp[0]});
         check(serr, (rnd[3] & ctrl_exp[5] & rnd[2]) | (rnd[1] & ctrl_exp[1]));
      end
   endtask : side_round
   // ----------------------------------------------------------------
   // read answer monitor
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (rvalid === 1'b1) begin
         if (exp_q.size() == 0) check(32'h1, 32'h0);
         else check(rdata, exp_q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      close_out();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {resetn, vga, iov, mabt, serren, card_system_error, cpd} = 7'h00;
      io_addr = 32'h0000_0000;
      rnd = 32'hcf63_3935;
      repeat (3) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      ctrl_exp = cbb_pkg::CTRL_RESET;
      base_exp = 32'h0000_0001;
      check({pf1, pf0, irq, card_reset_n, wpe}, 5'b11000);
      check(sysctl, 32'h0044_9060);
      rd(8'h3c, 32'h0340_0000);
      rd(8'h40, 32'h0000_0000);
      rd(8'h44, 32'h0000_0001);
      rd(8'h80, 32'h0044_9060);
      rd(8'h50, 32'h0000_0000);
      set_ctrl(16'hffff);
      rd(8'h3c, 32'h07ef_0000);
      for (int i = 0; i < 11; i++) begin
         set_ctrl(16'h0001 << i);
         side_round(6);
      end
      repeat (6) begin
         rnd = xs(rnd);
         set_ctrl(rnd[15:0]);
         side_round(8);
      end
      cbb_host_model_i.access(1'b1, 8'h3c, 4'h3, 32'hffff_ffff);
      rd(8'h3c, {ctrl_exp, 16'h0000});
      cbb_host_model_i.access(1'b1, 8'h40, 4'hf, 32'h1234_abcd);
      rd(8'h40, 32'h0000_0000);
      w = 32'h0044_9040;
      cbb_host_model_i.access(1'b1, 8'h80, 4'hf, w);
      check(sysctl, (w & cbb_pkg::SYSCTL_WMASK) | (32'h0044_9060 & ~cbb_pkg::SYSCTL_WMASK));
      cbb_host_model_i.access(1'b1, 8'h40, 4'hf, 32'h1234_abcd);
      rd(8'h40, 32'h1234_abcd);
      cbb_host_model_i.access(1'b1, 8'h80, 4'hf, 32'h0044_9060);
      cbb_host_model_i.access(1'b1, 8'h40, 4'hf, 32'h0000_0000);
      rd(8'h40, 32'h1234_abcd);
      rnd = xs(rnd);
      cbb_host_model_i.access(1'b1, 8'h44, 4'hf, rnd);
      base_exp = rnd | 32'h1;
      rd(8'h44, base_exp);
      side_round(24);
      set_ctrl(16'h0000);
      resetn = 1'b0;
      #1;
      check(card_reset_n, 1'b0);
      repeat (3) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      rd(8'h3c, 32'h0340_0000);
      for (int k = 0; k < 50 && exp_q.size() > 0; k++) @(posedge clk_sys);
      if (exp_q.size() > 0) bad_count++;
      close_out();
   end
endmodule : cardbus_bridge_config_regs_test
`default_nettype wire
